/* File: common/hsp_pkg.sv */
// shared constants and types for the two-channel serial port pin logic
package hsp_pkg;

	localparam int HSP_CHANNELS    = 2;
	localparam int HSP_DATA_W      = 8;
	localparam int HSP_FIFO_DEPTH  = 4;
	localparam int HSP_BIT_CNT_W   = 3;

	// reset values
	localparam logic HSP_DE_N_RESET = 1'h1;
	localparam logic HSP_TX_RESET   = 1'h1;

	// clock mode: strobe (mode 1) or frame sync pulse (mode 2)
	localparam logic HSP_MODE_STROBE = 1'h0;
	localparam logic HSP_MODE_SYNC   = 1'h1;

	// receive edge select
	localparam logic HSP_RX_FALLING = 1'h0;
	localparam logic HSP_RX_RISING  = 1'h1;

	// output drive select
	localparam logic HSP_DRIVE_PUSH_PULL = 1'h0;
	localparam logic HSP_DRIVE_OPEN_DRAIN = 1'h1;

	// driver enable function codes
	localparam logic [1:0] HSP_DE_DATA    = 2'h0;
	localparam logic [1:0] HSP_DE_ENABLED = 2'h1;
	localparam logic [1:0] HSP_DE_OFF     = 2'h2;
	localparam logic [1:0] HSP_DE_STROBE  = 2'h3;

	// field positions inside the synchronised configuration word
	localparam int HSP_CFG_W     = 8;
	localparam int HSP_CFG_EDGE  = 0;
	localparam int HSP_CFG_DRIVE = 1;
	localparam int HSP_CFG_TXEN  = 2;
	localparam int HSP_CFG_DEF0  = 3;
	localparam int HSP_CFG_DEF1  = 4;
	localparam int HSP_CFG_MODE  = 5;
	localparam int HSP_CFG_DBL   = 6;
	localparam int HSP_CFG_CTS   = 7;

	typedef enum logic [1:0] {
		HSP_TX_IDLE  = 2'b01,
		HSP_TX_SHIFT = 2'b10
	} hsp_tx_state_e;

endpackage

/* File: src/hsp_fifo.sv */
// small synchronous fifo with a registered output stage
`timescale 1ns/100ps
module hsp_fifo
	import hsp_pkg::*;
#(
	parameter int WIDTH = HSP_DATA_W,
	parameter int DEPTH = HSP_FIFO_DEPTH
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
		$error("hsp_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;
	logic [PW:0]      next_count;
	logic             next_out_valid;

	assign push = i_in_valid && o_in_ready;
	// move a word to the output stage when it is empty or being drained
	assign pop  = (count != '0) && (!o_out_valid || i_out_ready);

	// the output stage counts toward the depth
	always_comb begin
		next_count     = count + (PW+1)'(push) - (PW+1)'(pop);
		next_out_valid = pop || (o_out_valid && !i_out_ready);
	end

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			count      <= '0;
			o_in_ready <= 1'h1;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + PW'(1);
			end
			count      <= next_count;
			o_in_ready <= (next_count + (PW+1)'(next_out_valid)) != (PW+1)'(DEPTH);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_out_valid <= 1'h0;
			o_out_data  <= '0;
		end else if (pop) begin
			o_out_valid <= 1'h1;
			o_out_data  <= mem[rd_ptr];
		end else if (i_out_ready) begin
			o_out_valid <= 1'h0;
		end
	end

endmodule // hsp_fifo

/* File: src/hsp_serial_port.sv */
// two-channel serial port pin logic: receive, transmit, driver enable, collision
`timescale 1ns/100ps
module hsp_serial_port
	import hsp_pkg::*;
(
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	// channel A pins
	input  wire logic                   i_serial_clock_a,
	input  wire logic                   i_frame_sync_a,
	input  wire logic                   i_serial_rx_a,
	input  wire logic                   i_collision_in_a,
	output logic                        o_serial_tx_a,
	output logic                        o_serial_tx_oe_a,
	output logic                        o_driver_enable_n_a,
	// channel B pins
	input  wire logic                   i_serial_clock_b,
	input  wire logic                   i_frame_sync_b,
	input  wire logic                   i_serial_rx_b,
	input  wire logic                   i_collision_in_b,
	output logic                        o_serial_tx_b,
	output logic                        o_serial_tx_oe_b,
	output logic                        o_driver_enable_n_b,
	// configuration, bit 0 = channel A, bit 1 = channel B
	input  wire logic [HSP_CHANNELS-1:0] i_receive_edge_select,
	input  wire logic [HSP_CHANNELS-1:0] i_output_drive_select,
	input  wire logic [HSP_CHANNELS-1:0] i_transmit_output_enable,
	input  wire logic [HSP_CHANNELS-1:0] i_driver_enable_function_0,
	input  wire logic [HSP_CHANNELS-1:0] i_driver_enable_function_1,
	input  wire logic [HSP_CHANNELS-1:0] i_clock_mode,
	input  wire logic [HSP_CHANNELS-1:0] i_double_rate,
	input  wire logic [HSP_CHANNELS-1:0] i_clear_to_send_mode,
	// channel A data streams
	output logic      [HSP_DATA_W-1:0]  o_rx_data_a,
	output logic                        o_rx_valid_a,
	input  wire logic                   i_rx_ready_a,
	output logic                        o_rx_overrun_a,
	input  wire logic [HSP_DATA_W-1:0]  i_tx_data_a,
	input  wire logic                   i_tx_valid_a,
	output logic                        o_tx_ready_a,
	output logic                        o_collision_a,
	// channel B data streams
	output logic      [HSP_DATA_W-1:0]  o_rx_data_b,
	output logic                        o_rx_valid_b,
	input  wire logic                   i_rx_ready_b,
	output logic                        o_rx_overrun_b,
	input  wire logic [HSP_DATA_W-1:0]  i_tx_data_b,
	input  wire logic                   i_tx_valid_b,
	output logic                        o_tx_ready_b,
	output logic                        o_collision_b
);

	wire [HSP_CHANNELS-1:0] lclk     = {i_serial_clock_b, i_serial_clock_a};
	wire [HSP_CHANNELS-1:0] fs_pin   = {i_frame_sync_b, i_frame_sync_a};
	wire [HSP_CHANNELS-1:0] rx_pin   = {i_serial_rx_b, i_serial_rx_a};
	wire [HSP_CHANNELS-1:0] col_pin  = {i_collision_in_b, i_collision_in_a};
	wire [HSP_CHANNELS-1:0] rx_rdy   = {i_rx_ready_b, i_rx_ready_a};
	wire [HSP_CHANNELS-1:0] tx_vld   = {i_tx_valid_b, i_tx_valid_a};
	wire [HSP_DATA_W-1:0]   tx_din [HSP_CHANNELS];
	wire [HSP_CHANNELS-1:0] w_tx;
	wire [HSP_CHANNELS-1:0] w_oe;
	wire [HSP_CHANNELS-1:0] w_de_n;
	wire [HSP_CHANNELS-1:0] w_rx_valid;
	wire [HSP_CHANNELS-1:0] w_overrun;
	wire [HSP_CHANNELS-1:0] w_tx_ready;
	wire [HSP_CHANNELS-1:0] w_collision;
	wire [HSP_DATA_W-1:0]   w_rx_data [HSP_CHANNELS];

	assign tx_din[0] = i_tx_data_a;
	assign tx_din[1] = i_tx_data_b;

	genvar ch;
	for (ch = 0; ch < HSP_CHANNELS; ch++) begin : g_chan
		wire link_clk = lclk[ch];

		// ---- link domain ----
		logic [1:0]            lrst_q;
		logic                  lrst_n;
		logic [HSP_CFG_W-1:0]  cfg_m;
		logic [HSP_CFG_W-1:0]  cfg;
		logic                  col_m;
		logic                  col_s;
		logic                  rx_rise;
		logic                  rx_fall;
		logic                  fs_q;
		logic                  phase;
		logic                  take;
		logic                  rx_bit;
		logic [HSP_DATA_W-1:0] rx_sh;
		logic [HSP_BIT_CNT_W-1:0] rx_cnt;
		logic [HSP_DATA_W-1:0] rx_word;
		logic                  rx_tgl;
		logic                  txr_m;
		logic                  txr_s;
		logic                  txr_seen;
		hsp_tx_state_e         tx_state;
		logic [HSP_DATA_W-1:0] tx_sh;
		logic [HSP_BIT_CNT_W-1:0] tx_cnt;
		logic                  tx_bit;
		logic                  col_tgl;
		logic                  cts_ok;
		logic                  collide;
		logic                  next_de_n;
		logic                  next_oe;
		logic                  tx_q;
		logic                  oe_q;
		logic                  de_n_q;
		logic [1:0]            tx_hist;
		logic [1:0]            oe_hist;
		wire [HSP_CFG_W-1:0]   cfg_in = {i_clear_to_send_mode[ch], i_double_rate[ch],
			i_clock_mode[ch], i_driver_enable_function_1[ch],
			i_driver_enable_function_0[ch], i_transmit_output_enable[ch],
			i_output_drive_select[ch], i_receive_edge_select[ch]};

		// reset asserts at once, releases on the link clock
		always_ff @(posedge link_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				lrst_q <= 2'h0;
			end else begin
				lrst_q <= {lrst_q[0], 1'h1};
			end
		end
		assign lrst_n = lrst_q[1];

		// configuration is quasi-static; change it only while the channel idles
		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				cfg_m <= '0;
				cfg   <= '0;
				col_m <= 1'h0;
				col_s <= 1'h0;
				txr_m <= 1'h0;
				txr_s <= 1'h0;
			end else begin
				cfg_m <= cfg_in;
				cfg   <= cfg_m;
				col_m <= col_pin[ch];
				col_s <= col_m;
				txr_m <= g_core.req_tgl;
				txr_s <= txr_m;
			end
		end

		// capture the receive pin on both edges, choose one afterwards
		always_ff @(negedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				rx_fall <= 1'h0;
			end else begin
				rx_fall <= rx_pin[ch];
			end
		end

		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				rx_rise <= 1'h0;
				fs_q    <= 1'h0;
			end else begin
				rx_rise <= rx_pin[ch];
				fs_q    <= fs_pin[ch];
			end
		end

		assign rx_bit = (cfg[HSP_CFG_EDGE] == HSP_RX_RISING) ? rx_rise : rx_fall;

		// double rate: one bit every second clock, phase aligned by frame sync in sync mode only
		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				phase <= 1'h0;
			end else if (cfg[HSP_CFG_MODE] == HSP_MODE_SYNC && fs_q) begin
				phase <= 1'h1;
			end else begin
				phase <= ~phase;
			end
		end

		assign take = (!cfg[HSP_CFG_DBL] || !phase)
			&& (cfg[HSP_CFG_MODE] == HSP_MODE_SYNC || fs_q);

		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				rx_sh   <= '0;
				rx_cnt  <= '0;
				rx_word <= '0;
				rx_tgl  <= 1'h0;
			end else if (take) begin
				rx_sh <= {rx_bit, rx_sh[HSP_DATA_W-1:1]};
				if (cfg[HSP_CFG_MODE] == HSP_MODE_SYNC && fs_q) begin
					rx_cnt <= HSP_BIT_CNT_W'(1);
				end else begin
					rx_cnt <= rx_cnt + HSP_BIT_CNT_W'(1);
				end
				if (rx_cnt == '1) begin
					rx_word <= {rx_bit, rx_sh[HSP_DATA_W-1:1]};
					rx_tgl  <= ~rx_tgl;
				end
			end
		end

		assign cts_ok  = !(cfg[HSP_CFG_CTS] && col_s);
		assign tx_bit  = tx_sh[0];
		// bus mode: read-back passes two flops, so compare with the bit driven two cycles back
		assign collide = !cfg[HSP_CFG_CTS] && (tx_state == HSP_TX_SHIFT)
			&& oe_hist[1] && (col_s != tx_hist[1]);

		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				tx_state <= HSP_TX_IDLE;
				tx_sh    <= '0;
				tx_cnt   <= '0;
				txr_seen <= 1'h0;
				col_tgl  <= 1'h0;
			end else begin
				case (tx_state)
					HSP_TX_IDLE: begin
						if (take && txr_s != txr_seen && cts_ok) begin
							tx_sh    <= g_core.tx_byte;
							tx_cnt   <= '0;
							txr_seen <= txr_s;
							tx_state <= HSP_TX_SHIFT;
						end
					end
					HSP_TX_SHIFT: begin
						if (collide || !cts_ok) begin
							col_tgl  <= collide ? ~col_tgl : col_tgl;
							tx_state <= HSP_TX_IDLE;
						end else if (take) begin
							tx_sh  <= {1'h1, tx_sh[HSP_DATA_W-1:1]};
							tx_cnt <= tx_cnt + HSP_BIT_CNT_W'(1);
							if (tx_cnt == '1) begin
								tx_state <= HSP_TX_IDLE;
							end
						end
					end
					default: begin
						tx_state <= HSP_TX_IDLE;
					end
				endcase
			end
		end

		always_comb begin
			case ({cfg[HSP_CFG_DEF1], cfg[HSP_CFG_DEF0]})
				HSP_DE_DATA:    next_de_n = !(tx_state == HSP_TX_SHIFT);
				HSP_DE_ENABLED: next_de_n = !(tx_state == HSP_TX_SHIFT && cts_ok
					&& cfg[HSP_CFG_TXEN]);
				HSP_DE_OFF:     next_de_n = 1'h1;
				HSP_DE_STROBE:  next_de_n = !(tx_state == HSP_TX_SHIFT && fs_q);
				default:        next_de_n = 1'h1;
			endcase
		end

		assign next_oe = !next_de_n && cfg[HSP_CFG_TXEN]
			&& (cfg[HSP_CFG_DRIVE] == HSP_DRIVE_PUSH_PULL || !tx_bit);

		always_ff @(posedge link_clk or negedge lrst_n) begin
			if (!lrst_n) begin
				tx_q   <= HSP_TX_RESET;
				oe_q   <= 1'h0;
				de_n_q <= HSP_DE_N_RESET;
				tx_hist <= {2{HSP_TX_RESET}};
				oe_hist <= 2'h0;
			end else begin
				tx_q   <= (cfg[HSP_CFG_DRIVE] == HSP_DRIVE_OPEN_DRAIN) ? 1'h0 : tx_bit;
				oe_q   <= next_oe;
				de_n_q <= next_de_n;
				tx_hist <= {tx_hist[0], tx_q};
				oe_hist <= {oe_hist[0], oe_q};
			end
		end

		assign w_tx[ch]   = tx_q;
		assign w_oe[ch]   = oe_q;
		assign w_de_n[ch] = de_n_q;

		// ---- core domain ----
		if (1) begin : g_core
			logic [2:0]            rxt_q;
			logic [2:0]            ack_q;
			logic [2:0]            colt_q;
			logic                  req_tgl;
			logic [HSP_DATA_W-1:0] tx_byte;
			logic                  busy;
			logic                  tx_ready;
			logic                  rx_evt;
			logic                  in_ready;
			logic                  overrun;
			logic                  col_pulse;

			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					rxt_q  <= 3'h0;
					ack_q  <= 3'h0;
					colt_q <= 3'h0;
				end else begin
					rxt_q  <= {rxt_q[1:0], g_chan[ch].rx_tgl};
					ack_q  <= {ack_q[1:0], g_chan[ch].txr_seen};
					colt_q <= {colt_q[1:0], g_chan[ch].col_tgl};
				end
			end

			assign rx_evt = rxt_q[2] ^ rxt_q[1];

			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					req_tgl  <= 1'h0;
					tx_byte  <= '0;
					busy     <= 1'h0;
					tx_ready <= 1'h1;
				end else if (!busy && tx_ready && tx_vld[ch]) begin
					tx_byte  <= tx_din[ch];
					req_tgl  <= ~req_tgl;
					busy     <= 1'h1;
					tx_ready <= 1'h0;
				end else if (busy && ack_q[1] == req_tgl) begin
					busy     <= 1'h0;
					tx_ready <= 1'h1;
				end
			end

			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					overrun   <= 1'h0;
					col_pulse <= 1'h0;
				end else begin
					overrun   <= rx_evt && !in_ready;
					col_pulse <= colt_q[2] ^ colt_q[1];
				end
			end

			hsp_fifo #(
				.WIDTH (HSP_DATA_W),
				.DEPTH (HSP_FIFO_DEPTH)
			) u_rx_fifo (
				.i_core_clk  (i_core_clk),
				.i_rst_n     (i_rst_n),
				.i_in_valid  (rx_evt),
				.i_in_data   (g_chan[ch].rx_word),
				.o_in_ready  (in_ready),
				.o_out_valid (w_rx_valid[ch]),
				.o_out_data  (w_rx_data[ch]),
				.i_out_ready (rx_rdy[ch])
			);

			assign w_overrun[ch]   = overrun;
			assign w_tx_ready[ch]  = tx_ready;
			assign w_collision[ch] = col_pulse;
		end
	end

	assign o_serial_tx_a       = w_tx[0];
	assign o_serial_tx_oe_a    = w_oe[0];
	assign o_driver_enable_n_a = w_de_n[0];
	assign o_serial_tx_b       = w_tx[1];
	assign o_serial_tx_oe_b    = w_oe[1];
	assign o_driver_enable_n_b = w_de_n[1];
	assign o_rx_data_a         = w_rx_data[0];
	assign o_rx_valid_a        = w_rx_valid[0];
	assign o_rx_overrun_a      = w_overrun[0];
	assign o_tx_ready_a        = w_tx_ready[0];
	assign o_collision_a       = w_collision[0];
	assign o_rx_data_b         = w_rx_data[1];
	assign o_rx_valid_b        = w_rx_valid[1];
	assign o_rx_overrun_b      = w_overrun[1];
	assign o_tx_ready_b        = w_tx_ready[1];
	assign o_collision_b       = w_collision[1];

endmodule // hsp_serial_port

/* File: sim/hsp_serial_port_assertions.sv */
// concurrent checks on the serial port pins and byte streams
`timescale 1ns/100ps
module hsp_serial_port_assertions
	import hsp_pkg::*;
(
	input wire logic                    i_core_clk,
	input wire logic                    i_rst_n,
	input wire logic                    i_serial_clock_b,
	input wire logic                    i_collision_in_b,
	input wire logic                    o_serial_tx_b,
	input wire logic                    o_serial_tx_oe_b,
	input wire logic                    o_driver_enable_n_a,
	input wire logic                    o_driver_enable_n_b,
	input wire logic [HSP_CHANNELS-1:0] i_output_drive_select,
	input wire logic [HSP_CHANNELS-1:0] i_transmit_output_enable,
	input wire logic [HSP_CHANNELS-1:0] i_driver_enable_function_0,
	input wire logic [HSP_CHANNELS-1:0] i_driver_enable_function_1,
	input wire logic [HSP_CHANNELS-1:0] i_double_rate,
	input wire logic [HSP_CHANNELS-1:0] i_clear_to_send_mode,
	input wire logic [HSP_DATA_W-1:0]   o_rx_data_a,
	input wire logic                    o_rx_valid_a,
	input wire logic                    i_rx_ready_a,
	input wire logic                    i_tx_valid_b,
	input wire logic                    o_tx_ready_b
);
	wire logic [1:0] def_b = {i_driver_enable_function_1[1], i_driver_enable_function_0[1]};
	sequence s_de_start;
		!i_double_rate[1] ##0 $fell(o_driver_enable_n_b);
	endsequence
	sequence s_de_end;
		##[1:8] o_driver_enable_n_b;
	endsequence
	a_de_in_reset: assert property (@(posedge i_core_clk)
		!i_rst_n |-> o_driver_enable_n_a && o_driver_enable_n_b && !o_serial_tx_oe_b)
		else $error("driver enable low in reset");
	a_de_frame_len: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		s_de_start |-> s_de_end)
		else $error("driver enable low too long");
	a_de_forces_hiz: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		o_driver_enable_n_b |-> !o_serial_tx_oe_b)
		else $error("pin driven with driver enable high");
	a_txen_hiz: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		(!i_transmit_output_enable[1])[*6] |-> !o_serial_tx_oe_b)
		else $error("pin driven with transmit enable clear");
	a_open_drain_low: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		(i_output_drive_select[1])[*6] |-> !o_serial_tx_b)
		else $error("open drain pin drives high");
	a_push_pull_drive: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		(i_transmit_output_enable[1] && !i_output_drive_select[1])[*6] ##0
		!o_driver_enable_n_b |-> o_serial_tx_oe_b)
		else $error("push pull pin not driven");
	a_de_code_off: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		(def_b == HSP_DE_OFF || (def_b == HSP_DE_ENABLED && !i_transmit_output_enable[1]))[*6]
		|-> o_driver_enable_n_b)
		else $error("driver enable low while switched off");
	a_cts_blocks: assert property (@(posedge i_serial_clock_b) disable iff (!i_rst_n)
		(i_clear_to_send_mode[1] && i_collision_in_b)[*5] |-> !$fell(o_driver_enable_n_b))
		else $error("transmit started without clear to send");
	a_rx_holds: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		o_rx_valid_a && !i_rx_ready_a |=> o_rx_valid_a && $stable(o_rx_data_a))
		else $error("receive byte dropped before taken");
	a_tx_taken: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_tx_valid_b && o_tx_ready_b |=> !o_tx_ready_b)
		else $error("transmit ready stayed high after take");
endmodule // hsp_serial_port_assertions

bind hsp_serial_port hsp_serial_port_assertions u_chk (.i_core_clk, .i_rst_n, .i_serial_clock_b,
	.i_collision_in_b, .o_serial_tx_b, .o_serial_tx_oe_b, .o_driver_enable_n_a,
	.o_driver_enable_n_b, .i_output_drive_select, .i_transmit_output_enable,
	.i_driver_enable_function_0, .i_driver_enable_function_1, .i_double_rate,
	.i_clear_to_send_mode, .o_rx_data_a, .o_rx_valid_a, .i_rx_ready_a, .i_tx_valid_b,
	.o_tx_ready_b);

/* File: sim/hsp_link_partner.sv */
// link partner: sends receive bits with strobe, watches the transmit line
`timescale 1ns/100ps
module hsp_link_partner (
	input  wire logic       i_link_clk,
	input  wire logic       i_tx,
	input  wire logic       i_tx_oe,
	input  wire logic       i_de_n,
	input  wire logic [1:0] i_coll_sel,
	output logic            o_rx,
	output logic            o_frame_sync,
	output logic            o_collision_in
);
	logic       line;
	logic [7:0] cap;
	int         cnt;
	// pulled-up line: a released pin reads 1
	assign line = i_tx_oe ? i_tx : 1'b1;
	// 0 tied low, 1 bus wired back, 2 tied high
	assign o_collision_in = (i_coll_sel == 2'h1) ? line : i_coll_sel[1];
	initial begin
		o_rx = 1'b1;
		o_frame_sync = 1'b0;
		cnt = 0;
		cap = 8'h00;
	end
	always @(negedge i_link_clk) begin
		if (i_de_n === 1'b0) begin
			cap <= {line, cap[7:1]};
			cnt <= cnt + 1;
		end
	end
	task automatic clear();
		cnt = 0;
	endtask
	// rise_v seen around rising edges, fall_v around falling edges
	task automatic send_rx(input logic [7:0] rise_v, input logic [7:0] fall_v);
		for (int i = 0; i < 8; i++) begin
			@(negedge i_link_clk);
			o_rx <= rise_v[i];
			o_frame_sync <= 1'b1;
			@(posedge i_link_clk);
			o_rx <= fall_v[i];
		end
		@(negedge i_link_clk);
		o_rx <= 1'b1;
		o_frame_sync <= 1'b0;
	endtask
endmodule // hsp_link_partner

/* File: sim/test_hdlc_serial_port_pins.sv */
// self-checking bench for the two-channel serial port pin logic
`timescale 1ns/100ps
module test_hdlc_serial_port_pins;
	import hsp_pkg::*;
	logic i_core_clk = 1'b0, i_serial_clock_a = 1'b0, i_serial_clock_b = 1'b0, i_rst_n;
	logic i_frame_sync_a, i_frame_sync_b, i_serial_rx_a, i_serial_rx_b;
	logic i_collision_in_a, i_collision_in_b, o_serial_tx_a, o_serial_tx_oe_a;
	logic o_driver_enable_n_a, o_serial_tx_b, o_serial_tx_oe_b, o_driver_enable_n_b;
	logic [1:0] i_receive_edge_select, i_output_drive_select, i_transmit_output_enable;
	logic [1:0] i_driver_enable_function_0, i_driver_enable_function_1, i_clock_mode;
	logic [1:0] i_double_rate, i_clear_to_send_mode, coll_sel_b;
	logic [7:0] o_rx_data_a, i_tx_data_a, o_rx_data_b, i_tx_data_b;
	logic o_rx_valid_a, i_rx_ready_a, o_rx_overrun_a, i_tx_valid_a, o_tx_ready_a, o_collision_a;
	logic o_rx_valid_b, i_rx_ready_b, o_rx_overrun_b, i_tx_valid_b, o_tx_ready_b, o_collision_b;
	int err_total = 0, total_checks = 0, cyc = 0, ovr = 0, coll = 0, quiet = 0;

	always #20 i_core_clk = ~i_core_clk;
	always #7.5 i_serial_clock_a = ~i_serial_clock_a;
	initial begin
		#3.1;
		forever #7.5 i_serial_clock_b = ~i_serial_clock_b;
	end

	hsp_serial_port dut (.*);
	hsp_link_partner pa (.i_link_clk(i_serial_clock_a), .i_tx(o_serial_tx_a),
		.i_tx_oe(o_serial_tx_oe_a), .i_de_n(o_driver_enable_n_a), .i_coll_sel(2'h0),
		.o_rx(i_serial_rx_a), .o_frame_sync(i_frame_sync_a), .o_collision_in(i_collision_in_a));
	hsp_link_partner pb (.i_link_clk(i_serial_clock_b), .i_tx(o_serial_tx_b),
		.i_tx_oe(o_serial_tx_oe_b), .i_de_n(o_driver_enable_n_b), .i_coll_sel(coll_sel_b),
		.o_rx(i_serial_rx_b), .o_frame_sync(i_frame_sync_b), .o_collision_in(i_collision_in_b));

	task automatic finish_test();
		$display("mismatches %0d of %0d checks", err_total, total_checks);
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cnt(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp) begin
			err_total++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic rd_rx(output logic [7:0] d);
		int n;
		n = 0;
		@(negedge i_core_clk);
		while (o_rx_valid_a !== 1'b1 && n < 200) begin
			@(negedge i_core_clk);
			n++;
		end
		d = (n < 200) ? o_rx_data_a : 8'hxx;
		@(posedge i_core_clk) i_rx_ready_a <= 1'b1;
		@(posedge i_core_clk) i_rx_ready_a <= 1'b0;
	endtask
	task automatic put_tx(input logic [7:0] d);
		int n;
		@(posedge i_core_clk);
		i_tx_data_b <= d;
		i_tx_valid_b <= 1'b1;
		for (n = 0; n < 300 && o_tx_ready_b !== 1'b1; n++)
			@(posedge i_core_clk);
		@(posedge i_core_clk);
		i_tx_valid_b <= 1'b0;
		chk_cnt("tx handshake", 1, n < 300);
	endtask
	task automatic cfg_tx(input logic [1:0] code, input logic od, en, cts, input logic [1:0] sel);
		@(posedge i_core_clk);
		{i_driver_enable_function_1[1], i_driver_enable_function_0[1]} <= code;
		i_output_drive_select[1] <= od;
		i_transmit_output_enable[1] <= en;
		i_clear_to_send_mode[1] <= cts;
		coll_sel_b <= sel;
		repeat (4) @(posedge i_core_clk);
		pb.clear();
		coll = 0;
	endtask
	task automatic run_tx(input logic [1:0] code, input logic od, en, cts, input logic [1:0] sel,
			input logic [7:0] d, input int exp_n, input logic [7:0] exp_d, input int exp_c);
		cfg_tx(code, od, en, cts, sel);
		put_tx(d);
		repeat (25) @(posedge i_core_clk);
		if (exp_n >= 0) chk_cnt("de low bits", exp_n, pb.cnt);
		if (exp_n == 8) chk_byte("line byte", exp_d, pb.cap);
		chk_cnt("collision pulses", exp_c, coll);
	endtask

	always @(posedge i_core_clk) begin
		cyc++;
		if (o_rx_overrun_a === 1'b1) ovr++;
		if (o_collision_b === 1'b1) coll++;
		if (o_rx_overrun_b !== 1'b0 || o_collision_a !== 1'b0) quiet++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end

	always @(negedge i_core_clk) begin
		if (o_rx_valid_b === 1'b1) chk_byte("rx b idle byte", 8'hff, o_rx_data_b);
	end

	initial begin
		logic [7:0] d;
		int         n;
		{i_rst_n, i_tx_valid_a, i_tx_valid_b, i_rx_ready_a, i_tx_data_a, i_tx_data_b} = '0;
		i_rx_ready_b = 1'b1;
		i_receive_edge_select = 2'h1;
		i_output_drive_select = 2'h0;
		i_transmit_output_enable = 2'h3;
		{i_driver_enable_function_0, i_driver_enable_function_1} = '0;
		i_clock_mode = 2'h2;
		{i_double_rate, i_clear_to_send_mode} = '0;
		coll_sel_b = 2'h1;
		repeat (3) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk_byte("de in reset", 8'h03, {6'h0, o_driver_enable_n_a, o_driver_enable_n_b});
		@(posedge i_core_clk) i_rst_n <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		// channel A receives with strobe, then channel B transmits in sync mode
		pa.send_rx(8'h96, 8'h69);
		rd_rx(d);
		chk_byte("rx rising edge", 8'h96, d);
		@(posedge i_core_clk) i_receive_edge_select[0] <= 1'b0;
		repeat (4) @(posedge i_core_clk);
		pa.send_rx(8'h96, 8'h69);
		rd_rx(d);
		chk_byte("rx falling edge", 8'h69, d);
		repeat (40) @(posedge i_core_clk);
		chk_byte("rx idle outside strobe", 8'h00, {7'h0, o_rx_valid_a});
		@(posedge i_core_clk) i_clock_mode[0] <= 1'b1;
		repeat (200) @(posedge i_core_clk);
		i_clock_mode[0] <= 1'b0;
		repeat (10) @(posedge i_core_clk);
		chk_cnt("overrun seen", 1, ovr > 0);
		for (n = 0; n < 8; n++) begin
			@(negedge i_core_clk);
			if (o_rx_valid_a !== 1'b1) break;
			rd_rx(d);
			chk_byte("fill byte", 8'hff, d);
		end
		chk_cnt("fifo words", HSP_FIFO_DEPTH, n);
		run_tx(HSP_DE_DATA, 0, 1, 0, 2'h1, 8'ha5, 8, 8'ha5, 0);
		run_tx(HSP_DE_ENABLED, 0, 1, 0, 2'h1, 8'h5a, 8, 8'h5a, 0);
		run_tx(HSP_DE_OFF, 0, 1, 0, 2'h1, 8'h33, 0, 8'h00, 0);
		run_tx(HSP_DE_STROBE, 0, 1, 0, 2'h1, 8'hc3, 0, 8'h00, 0);
		run_tx(HSP_DE_DATA, 1, 1, 1, 2'h0, 8'h3c, 8, 8'h3c, 0);
		run_tx(HSP_DE_DATA, 0, 0, 1, 2'h0, 8'h81, 8, 8'hff, 0);
		run_tx(HSP_DE_ENABLED, 0, 0, 1, 2'h0, 8'h81, 0, 8'h00, 0);
		run_tx(HSP_DE_DATA, 0, 1, 0, 2'h0, 8'hf0, -1, 8'h00, 1);
		i_double_rate[1] <= 1'b1;
		run_tx(HSP_DE_DATA, 0, 1, 0, 2'h1, 8'h0f, 16, 8'h00, 0);
		i_double_rate[1] <= 1'b0;
		cfg_tx(HSP_DE_DATA, 0, 1, 1, 2'h2);
		put_tx(8'h99);
		repeat (30) @(posedge i_core_clk);
		chk_cnt("blocked bits", 0, pb.cnt);
		chk_byte("tx ready while blocked", 8'h00, {7'h0, o_tx_ready_b});
		coll_sel_b <= 2'h0;
		repeat (30) @(posedge i_core_clk);
		chk_cnt("released bits", 8, pb.cnt);
		chk_byte("released byte", 8'h99, pb.cap);
		chk_cnt("quiet pulses", 0, quiet);
		chk_cnt("a de low bits", 0, pa.cnt);
		chk_byte("a tx idle pins", 8'h05, {5'h0, o_driver_enable_n_a, o_serial_tx_oe_a, o_tx_ready_a});
		finish_test();
	end
endmodule // test_hdlc_serial_port_pins
